// File: src/hsa_cfg.svh
// constants for the hot swap alert status byte
`ifndef HSA_CFG_SVH
`define HSA_CFG_SVH
`define HSA_BIT_ADC_NOW 0
`define HSA_BIT_ADC_ALERT 1
`define HSA_BIT_HOT_SWAP_OVERCURRENT 2
`define HSA_BIT_HS_FAIL 3
`define HSA_BIT_OFF_NOW 4
`define HSA_BIT_OFF_ALERT 5
`define HSA_STICKY_CNT 3
`define HSA_STICKY_ADC 0
`define HSA_STICKY_HS 1
`define HSA_STICKY_OFF 2
`define HSA_HIST_LEN 3
`define HSA_SPARE_BITS 2'b00
`define HSA_FLAG_RST 1'b0
`define HSA_HIST_RST 3'h0
`define HSA_BYTE_RST 8'h00
`define HSA_CNT_RST 3'h0
`define HSA_LAST_BIT 3'h7
`define HSA_CNT_STEP 3'h1
`define HSA_ADDR_W 7
`endif

// File: src/hsa_pkg.sv
// types for the hot swap alert status byte
package hsa_pkg;
   typedef enum logic [5:0] {
      HSA_IDLE = 6'h01,
      HSA_ADDR = 6'h02,
      HSA_ADDR_CHK = 6'h04,
      HSA_ACK = 6'h08,
      HSA_SEND = 6'h10,
      HSA_MACK = 6'h20
   } hsa_state_e;
endpackage : hsa_pkg

// File: src/hsa_sticky_flag.sv
// one sticky alert flag, set wins over clear
`timescale 1ns/1ps
`include "hsa_cfg.svh"
module hsa_sticky_flag (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic set_cond,
   input wire logic clear_now,
   output logic flag_r
);
   wire logic flag_nxt = set_cond | (flag_r & ~clear_now);

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         flag_r <= `HSA_FLAG_RST;
      end else if (ce) begin
         flag_r <= flag_nxt;
      end
   end
endmodule : hsa_sticky_flag

// File: src/hsa_status_byte.sv
// hot swap alert status byte with its serial read-only responder
// Overview of operation
// - bit 0 is high while the last three current conversions exceeded the threshold.
// - bit 1 sets on an ADC overcurrent alert trip, held until clear.
// - bit 2 shows hot swap off by analog overcurrent; latch-off follows the present cause, unlike sticky bit 3.
// - retry variant bit 2 shows present state, 0 while retrying or recovered.
// - bit 3 sets when hot swap fails, held until clear.
// - bit 4 reads 1 while the ON pin is deasserted.
// - bit 4 also reads 1 while software off is set.
// - bit 5 sets on switch-off by ON pin or software off, held until clear.
// - clear request clears bits 1, 3, 5; self-clears; only bit 3 sets again while its cause holds; bit 1 needs a new trip, bit 5 a new switch-off.
// - master reads with start, 7-bit address, read bit, ack, then the byte.
`timescale 1ns/1ps
`include "hsa_cfg.svh"
module hsa_status_byte #(
   parameter bit LATCH_OFF = 1'b1,
   parameter int ADDR_W = `HSA_ADDR_W
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic [ADDR_W-1:0] dev_addr,
   input wire logic conv_done,
   input wire logic adc_over_thresh,
   input wire logic en_adc_oc1,
   input wire logic en_adc_oc4,
   input wire logic hot_swap_overcurrent_off,
   input wire logic hs_retrying,
   input wire logic hot_swap_alert_enable,
   input wire logic on_pin,
   input wire logic software_off,
   input wire logic off_alert_enable,
   input wire logic clear_req,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   output logic clear_done,
   output logic [7:0] status_byte
);
   logic [`HSA_HIST_LEN-1:0] hist_r;
   logic adc_overcurrent_now_r;
   logic hot_swap_overcurrent_r;
   logic power_off_state_r;
   logic [`HSA_STICKY_CNT-1:0] sticky_q;
   logic [`HSA_STICKY_CNT-1:0] sticky_set;
   logic scl_q;
   logic sda_q;
   hsa_pkg::hsa_state_e state_r, state_nxt;
   logic [2:0] cnt_r, cnt_nxt;
   logic [7:0] shift_r, shift_nxt;
   logic oe_r, oe_nxt;
   logic sda_out_r;
   logic clear_done_r;

   // conversion history and alert causes
   wire logic [`HSA_HIST_LEN-1:0] hist_nxt = conv_done ?
      {hist_r[`HSA_HIST_LEN-2:0], adc_over_thresh} : hist_r;
   wire logic hist_all = &hist_r;
   wire logic four_in_row = adc_over_thresh & hist_all;
   wire logic adc_trip = conv_done & adc_over_thresh & (en_adc_oc1 | (en_adc_oc4 & four_in_row));
   wire logic hot_swap_overcurrent_nxt = LATCH_OFF ? hot_swap_overcurrent_off : (hot_swap_overcurrent_off & ~hs_retrying);
   wire logic power_off_nxt = ~on_pin | software_off;
   wire logic off_event = power_off_nxt & ~power_off_state_r;

   assign sticky_set[`HSA_STICKY_ADC] = adc_trip;
   assign sticky_set[`HSA_STICKY_HS] = hot_swap_overcurrent_off & hot_swap_alert_enable;
   assign sticky_set[`HSA_STICKY_OFF] = off_event & off_alert_enable;

   // bits 1, 3 and 5
   for (genvar g = 0; g < `HSA_STICKY_CNT; g++) begin : g_sticky
      hsa_sticky_flag u_flag (
         .core_clk(core_clk),
         .rst_n(rst_n),
         .ce(ce),
         .set_cond(sticky_set[g]),
         .clear_now(clear_req),
         .flag_r(sticky_q[g])
      );
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         hist_r <= `HSA_HIST_RST;
         adc_overcurrent_now_r <= `HSA_FLAG_RST;
         hot_swap_overcurrent_r <= `HSA_FLAG_RST;
         power_off_state_r <= `HSA_FLAG_RST;
         clear_done_r <= `HSA_FLAG_RST;
      end else if (ce) begin
         hist_r <= hist_nxt;
         adc_overcurrent_now_r <= hist_all;
         hot_swap_overcurrent_r <= hot_swap_overcurrent_nxt;
         power_off_state_r <= power_off_nxt;
         clear_done_r <= clear_req;
      end
   end

   // status byte image, spare bits zero
   wire logic [7:0] status_img = {`HSA_SPARE_BITS,
      sticky_q[`HSA_STICKY_OFF], power_off_state_r,
      sticky_q[`HSA_STICKY_HS], hot_swap_overcurrent_r,
      sticky_q[`HSA_STICKY_ADC], adc_overcurrent_now_r};

   // bus condition decode on sampled pins
   wire logic scl_rise = scl_in & ~scl_q;
   wire logic scl_fall = ~scl_in & scl_q;
   wire logic start_cond = scl_in & scl_q & sda_q & ~sda_in;
   wire logic stop_cond = scl_in & scl_q & ~sda_q & sda_in;
   wire logic addr_hit = (shift_r[7:1] == dev_addr) & shift_r[0];
   wire logic last_bit = (cnt_r == `HSA_LAST_BIT);

   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      shift_nxt = shift_r;
      oe_nxt = oe_r;
      if (start_cond) begin
         state_nxt = hsa_pkg::HSA_ADDR;
         cnt_nxt = `HSA_CNT_RST;
         oe_nxt = 1'b0;
      end else if (stop_cond) begin
         state_nxt = hsa_pkg::HSA_IDLE;
         oe_nxt = 1'b0;
      end else begin
         unique case (state_r)
            hsa_pkg::HSA_IDLE: begin
               oe_nxt = 1'b0;
            end
            hsa_pkg::HSA_ADDR: begin
               if (scl_rise) begin
                  shift_nxt = {shift_r[6:0], sda_in};
                  cnt_nxt = cnt_r + `HSA_CNT_STEP;
                  if (last_bit) begin
                     state_nxt = hsa_pkg::HSA_ADDR_CHK;
                  end
               end
            end
            hsa_pkg::HSA_ADDR_CHK: begin
               if (scl_fall) begin
                  oe_nxt = addr_hit;
                  state_nxt = addr_hit ? hsa_pkg::HSA_ACK : hsa_pkg::HSA_IDLE;
               end
            end
            hsa_pkg::HSA_ACK: begin
               if (scl_fall) begin
                  shift_nxt = status_img;
                  oe_nxt = ~status_img[7];
                  cnt_nxt = `HSA_CNT_RST;
                  state_nxt = hsa_pkg::HSA_SEND;
               end
            end
            hsa_pkg::HSA_SEND: begin
               if (scl_fall) begin
                  if (last_bit) begin
                     oe_nxt = 1'b0;
                     state_nxt = hsa_pkg::HSA_MACK;
                  end else begin
                     shift_nxt = {shift_r[6:0], 1'b0};
                     oe_nxt = ~shift_r[6];
                     cnt_nxt = cnt_r + `HSA_CNT_STEP;
                  end
               end
            end
            hsa_pkg::HSA_MACK: begin
               if (scl_rise) begin
                  state_nxt = sda_in ? hsa_pkg::HSA_IDLE : hsa_pkg::HSA_ACK;
               end
            end
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         state_r <= hsa_pkg::HSA_IDLE;
         cnt_r <= `HSA_CNT_RST;
         shift_r <= `HSA_BYTE_RST;
         oe_r <= `HSA_FLAG_RST;
         sda_out_r <= `HSA_FLAG_RST;
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else if (ce) begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         shift_r <= shift_nxt;
         oe_r <= oe_nxt;
         sda_out_r <= `HSA_FLAG_RST;
         scl_q <= scl_in;
         sda_q <= sda_in;
      end
   end

   assign sda_out = sda_out_r;
   assign sda_oe = oe_r;
   assign clear_done = clear_done_r;
   assign status_byte = status_img;

   // checks
   AST_ADC_NOW: assert property (@(posedge core_clk) disable iff (!rst_n)
      ce |=> status_byte[`HSA_BIT_ADC_NOW] == $past(hist_all))
      else $error("adc overcurrent now does not follow three conversions");
   AST_ADC_ALERT: assert property (@(posedge core_clk) disable iff (!rst_n)
      (ce && adc_trip) |=> status_byte[`HSA_BIT_ADC_ALERT])
      else $error("adc alert not set by trip");
   AST_HS_LATCH: assert property (@(posedge core_clk) disable iff (!rst_n)
      (LATCH_OFF && ce && hot_swap_overcurrent_off && hot_swap_alert_enable) |=>
      status_byte[`HSA_BIT_HOT_SWAP_OVERCURRENT] && status_byte[`HSA_BIT_HS_FAIL])
      else $error("latch-off overcurrent bits disagree");
   AST_HS_RETRY: assert property (@(posedge core_clk) disable iff (!rst_n)
      (!LATCH_OFF && ce && hs_retrying) |=> !status_byte[`HSA_BIT_HOT_SWAP_OVERCURRENT])
      else $error("retry overcurrent bit high while retrying");
   AST_HS_HOLD: assert property (@(posedge core_clk) disable iff (!rst_n)
      (status_byte[`HSA_BIT_HS_FAIL] && !clear_req) |=> status_byte[`HSA_BIT_HS_FAIL])
      else $error("hot swap fail alert lost without clear");
   AST_OFF_NOW: assert property (@(posedge core_clk) disable iff (!rst_n)
      ce |=> status_byte[`HSA_BIT_OFF_NOW] == ($past(software_off) || !$past(on_pin)))
      else $error("power off state wrong");
   AST_OFF_ALERT: assert property (@(posedge core_clk) disable iff (!rst_n)
      (ce && off_alert_enable && power_off_nxt && !status_byte[`HSA_BIT_OFF_NOW])
      |=> status_byte[`HSA_BIT_OFF_ALERT])
      else $error("power off alert not set on switch-off");
   AST_CLEAR: assert property (@(posedge core_clk) disable iff (!rst_n)
      (ce && clear_req && sticky_set == 3'h0) |=> (sticky_q == 3'h0) && clear_done)
      else $error("clear did not clear alert bits");
   AST_SPARE: assert property (@(posedge core_clk) disable iff (!rst_n)
      status_byte[7:6] == `HSA_SPARE_BITS)
      else $error("spare status bits not zero");
   AST_ACK: assert property (@(posedge core_clk) disable iff (!rst_n)
      (ce && state_r == hsa_pkg::HSA_ADDR_CHK && scl_fall && !start_cond && !stop_cond
      && addr_hit) |=> sda_oe ##0 state_r == hsa_pkg::HSA_ACK)
      else $error("address match not acknowledged");
endmodule : hsa_status_byte

// File: sim/hsa_i2c_master.sv
// serial bus master model that reads the status byte
`timescale 1ns/1ps
module hsa_i2c_master (
   input wire logic core_clk,
   input wire logic sda_oe,
   output logic scl,
   output logic sda_line
);
   logic drv_low;
   // pull-up: line is high unless someone pulls it low
   assign sda_line = ~(drv_low | sda_oe);
   initial begin
      scl = 1'b1;
      drv_low = 1'b0;
   end
   task automatic half();
      repeat (4) @(posedge core_clk);
   endtask : half
   task automatic clk_bit(input logic b, output logic got);
      drv_low <= ~b;
      half();
      scl <= 1'b1;
      half();
      got = sda_line;
      scl <= 1'b0;
      half();
   endtask : clk_bit
   task automatic read(input logic [6:0] a, output logic ack, output logic [7:0] d);
      logic g;
      @(posedge core_clk);
      drv_low <= 1'b1;
      half();
      scl <= 1'b0;
      half();
      for (int i = 6; i >= 0; i--) clk_bit(a[i], g);
      clk_bit(1'b1, g);
      clk_bit(1'b1, g);
      ack = ~g;
      for (int i = 7; i >= 0; i--) clk_bit(1'b1, d[i]);
      clk_bit(1'b1, g);
      drv_low <= 1'b1;
      half();
      scl <= 1'b1;
      half();
      drv_low <= 1'b0;
      half();
   endtask : read
endmodule : hsa_i2c_master

// File: sim/hsa_status_byte_tb.sv
// self-checking bench for the alert status byte
`timescale 1ns/1ps
module hsa_status_byte_tb;
   localparam logic [6:0] ADDR = 7'h2c;
   logic core_clk = 1'b0, rst_n = 1'b0, conv_done = 1'b0, over = 1'b0, en1 = 1'b0;
   logic en4 = 1'b0, hot_swap_overcurrent_off = 1'b0, hs_retrying = 1'b0, hs_en = 1'b0, on_pin = 1'b1;
   logic sw_off = 1'b0, off_en = 1'b0, clear_req = 1'b0, ce = 1'b1, ack;
   logic scl, sda_line, sda_out, sda_oe, clear_done;
   logic [7:0] status, status2, d;
   int n_errors = 0, check_count = 0;
   always #2.5 core_clk = ~core_clk;
   hsa_status_byte #(.LATCH_OFF(1'b1)) dut (.core_clk(core_clk), .rst_n(rst_n), .ce(ce),
      .dev_addr(ADDR), .conv_done(conv_done), .adc_over_thresh(over), .en_adc_oc1(en1),
      .en_adc_oc4(en4), .hot_swap_overcurrent_off(hot_swap_overcurrent_off), .hs_retrying(hs_retrying),
      .hot_swap_alert_enable(hs_en), .on_pin(on_pin), .software_off(sw_off),
      .off_alert_enable(off_en), .clear_req(clear_req), .scl_in(scl), .sda_in(sda_line),
      .sda_out(sda_out), .sda_oe(sda_oe), .clear_done(clear_done), .status_byte(status));
   hsa_status_byte #(.LATCH_OFF(1'b0)) dut_retry (.core_clk(core_clk), .rst_n(rst_n),
      .ce(ce), .dev_addr(ADDR), .conv_done(conv_done), .adc_over_thresh(over),
      .en_adc_oc1(en1), .en_adc_oc4(en4), .hot_swap_overcurrent_off(hot_swap_overcurrent_off), .hs_retrying(hs_retrying),
      .hot_swap_alert_enable(hs_en), .on_pin(on_pin), .software_off(sw_off),
      .off_alert_enable(off_en), .clear_req(clear_req), .scl_in(1'b1), .sda_in(1'b1),
      .sda_out(), .sda_oe(), .clear_done(), .status_byte(status2));
   hsa_i2c_master mst (.core_clk(core_clk), .sda_oe(sda_oe), .scl(scl), .sda_line(sda_line));
   task automatic end_sim();
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : end_sim
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
   endtask : tick
   task automatic conv(input logic o);
      @(posedge core_clk);
      conv_done <= 1'b1;
      over <= o;
      @(posedge core_clk);
      conv_done <= 1'b0;
   endtask : conv
   task automatic clr();
      @(posedge core_clk);
      clear_req <= 1'b1;
      @(posedge core_clk);
      clear_req <= 1'b0;
      #1 chk({7'h00, clear_done}, 8'h01);
      tick(1);
      #1 chk({7'h00, clear_done}, 8'h00);
   endtask : clr
   task automatic adc_scn();
      repeat (3) conv(1'b1);
      tick(3);
      #1 chk(status, 8'h01);
      conv(1'b0);
      tick(3);
      #1 chk(status, 8'h00);
      tick(1);
      en4 <= 1'b1;
      repeat (3) conv(1'b1);
      tick(3);
      #1 chk(status, 8'h01);
      conv(1'b1);
      tick(3);
      en4 <= 1'b0;
      conv(1'b0);
      tick(3);
      #1 chk(status, 8'h02);
      clr();
      chk(status, 8'h00);
      tick(1);
      en1 <= 1'b1;
      conv(1'b1);
      tick(3);
      en1 <= 1'b0;
      #1 chk(status, 8'h02);
      clr();
   endtask : adc_scn
   task automatic hs_scn();
      tick(1);
      hot_swap_overcurrent_off <= 1'b1;
      hs_en <= 1'b1;
      hs_retrying <= 1'b1;
      tick(3);
      #1 chk(status, 8'h0c);
      chk(status2, 8'h08);
      clr();
      tick(2);
      #1 chk(status, 8'h0c);
      tick(1);
      hs_retrying <= 1'b0;
      tick(3);
      #1 chk(status2, 8'h0c);
      tick(1);
      hot_swap_overcurrent_off <= 1'b0;
      tick(3);
      #1 chk(status, 8'h08);
      chk(status2, 8'h08);
      clr();
      chk(status, 8'h00);
   endtask : hs_scn
   task automatic off_scn();
      tick(1);
      off_en <= 1'b1;
      on_pin <= 1'b0;
      tick(3);
      #1 chk(status, 8'h30);
      tick(1);
      on_pin <= 1'b1;
      tick(3);
      #1 chk(status, 8'h20);
      tick(1);
      sw_off <= 1'b1;
      tick(3);
      #1 chk(status, 8'h30);
      mst.read(ADDR, ack, d);
      chk({7'h00, ack}, 8'h01);
      chk(d, 8'h30);
      mst.read(ADDR ^ 7'h01, ack, d);
      chk({7'h00, ack}, 8'h00);
      chk({6'h00, sda_out, sda_oe}, 8'h00);
      clr();
      chk(status, 8'h10);
   endtask : off_scn
   // clock enable low must freeze every flag
   task automatic ce_scn();
      tick(1);
      ce <= 1'b0;
      sw_off <= 1'b0;
      tick(3);
      #1 chk(status, 8'h10);
      chk(status2, 8'h10);
      tick(1);
      ce <= 1'b1;
      tick(2);
      #1 chk(status, 8'h00);
      chk(status2, 8'h00);
   endtask : ce_scn
   initial begin
      tick(10);
      rst_n <= 1'b1;
      tick(1);
      #1 chk(status, 8'h00);
      chk({5'h00, sda_out, sda_oe, clear_done}, 8'h00);
      adc_scn();
      hs_scn();
      off_scn();
      ce_scn();
      end_sim();
   end
   initial begin
      tick(20000);
      n_errors++;
      end_sim();
   end
endmodule : hsa_status_byte_tb
